/* File: cpu_branch_flag_compare_decode.sv */
// Purpose: Fetch and execute core for overflow branches, flag clears and compare
// Assumes: Memory returns mem_data_in for mem_addr_out within the same cycle
// Notes: Software may change PC and status only while the core is idle
`timescale 1ns/1ps
// Summary of operation
// - Opcode 70 branches when overflow is 1, else falls through; two cycles base.
// - Opcode 50 branches when overflow is 0, else falls through; two cycles base.
// - Taken overflow branch within the same page costs one extra cycle.
// - Taken overflow branch into another page costs two extra cycles.
// - Interrupt-disable clear sets that flag to 0, other flags untouched.
// - Compare subtracts operand from accumulator, sets N Z C, keeps I D V.
// - Compare takes 2,3,4,4,4,4,6,5 cycles, plus one on indexed page cross.
module cpu_branch_flag_compare_decode (
    input wire logic clock_in, // System clock, 250 MHz
    input wire logic nrst_in, // Asynchronous reset, active low
    input wire logic [3:0] reg_addr_in, // Register index
    input wire logic [7:0] reg_wdata_in, // Register write data
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
    output logic [15:0] mem_addr_out, // Memory address
    output logic mem_rd_out, // Memory read enable
    input wire logic [7:0] mem_data_in // Memory read data
);
    typedef enum logic [9:0] {
        S_FETCH = 10'h001, S_IMPL = 10'h002, S_OPER1 = 10'h004, S_OPER2 = 10'h008,
        S_ZPIDX = 10'h010, S_PTR_LO = 10'h020, S_PTR_HI = 10'h040,
        S_FIXHI = 10'h080, S_READ = 10'h100, S_BR_TAKE = 10'h200
    } state_e;

    state_e state;
    logic br_fix;
    logic run;
    logic bad_op;
    logic [7:0] stat;
    logic [7:0] acc;
    logic [7:0] xidx;
    logic [7:0] yidx;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [7:0] ptr;
    logic [7:0] opcode;
    logic [2:0] cyc_cnt;
    decode_if dec ();

    logic idle;
    logic sw_wr;
    logic acmp_exec;
    logic br_taken;
    logic [15:0] br_target;
    logic br_cross;
    logic [7:0] idx_val;
    logic [7:0] base_lo;
    logic [8:0] idx_sum;
    logic [7:0] zp_sum;
    logic [15:0] ea_bus;
    logic [7:0] acmp_diff;

    cpu_op_decode i_cpu_op_decode (
        .dec(dec)
    );

    // Decode the live byte while fetching so no decode cycle is lost
    assign dec.opcode = (state == S_FETCH) ? mem_data_in : opcode;
    assign idle = (state == S_FETCH) && !run;
    assign sw_wr = reg_wr_in && idle;
    assign acmp_exec = (dec.kind == cpu_decode_pkg::K_ACMP)
        && ((state == S_READ) || (state == S_OPER1 && dec.mode == cpu_decode_pkg::M_IMM));
    assign br_taken = (dec.kind == cpu_decode_pkg::K_BR_SET) ? stat[cpu_decode_pkg::FLAG_V]
        : (dec.kind == cpu_decode_pkg::K_BR_CLR) && !stat[cpu_decode_pkg::FLAG_V];
    assign br_target = pc + {{8{ptr[7]}}, ptr};
    assign br_cross = br_target[15:8] != pc[15:8];
    assign zp_sum = ptr + xidx;
    assign idx_val = (dec.mode == cpu_decode_pkg::M_ABSX) ? xidx
        : (dec.mode == cpu_decode_pkg::M_ABSY || dec.mode == cpu_decode_pkg::M_INDY) ? yidx
        : cpu_decode_pkg::ZERO_PAGE;
    assign base_lo = (state == S_OPER2) ? ptr : ea[7:0];
    assign idx_sum = {1'b0, base_lo} + {1'b0, idx_val};
    assign mem_addr_out = ea_bus;

    // Sequencer and address path
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= S_FETCH;
            br_fix <= 1'b0;
            ea_bus <= cpu_decode_pkg::PC_RESET;
            ea <= cpu_decode_pkg::PC_RESET;
            ptr <= cpu_decode_pkg::ZERO_PAGE;
            opcode <= cpu_decode_pkg::ZERO_PAGE;
        end else begin
            case (state)
                S_FETCH: begin
                    if (run && dec.kind != cpu_decode_pkg::K_BAD) begin
                        opcode <= mem_data_in;
                        ea_bus <= pc + 16'h0001;
                        state <= (dec.mode == cpu_decode_pkg::M_NONE) ? S_IMPL : S_OPER1;
                    end else begin
                        ea_bus <= pc;
                    end
                end
                S_IMPL: begin
                    ea_bus <= pc;
                    state <= S_FETCH;
                end
                S_OPER1: begin
                    ptr <= mem_data_in;
                    ea_bus <= pc + 16'h0001;
                    state <= S_FETCH;
                    case (dec.mode)
                        cpu_decode_pkg::M_REL: begin
                            if (br_taken) begin
                                state <= S_BR_TAKE;
                            end
                        end
                        cpu_decode_pkg::M_ZP: begin
                            ea_bus <= {cpu_decode_pkg::ZERO_PAGE, mem_data_in};
                            state <= S_READ;
                        end
                        cpu_decode_pkg::M_ZPX, cpu_decode_pkg::M_INDX: begin
                            ea_bus <= {cpu_decode_pkg::ZERO_PAGE, mem_data_in};
                            state <= S_ZPIDX;
                        end
                        cpu_decode_pkg::M_INDY: begin
                            ea_bus <= {cpu_decode_pkg::ZERO_PAGE, mem_data_in};
                            state <= S_PTR_LO;
                        end
                        cpu_decode_pkg::M_ABS, cpu_decode_pkg::M_ABSX,
                        cpu_decode_pkg::M_ABSY: begin
                            state <= S_OPER2;
                        end
                        default: begin
                            state <= S_FETCH;
                        end
                    endcase
                end
                S_ZPIDX: begin
                    // Zero-page index wraps inside page zero
                    ptr <= zp_sum;
                    ea_bus <= {cpu_decode_pkg::ZERO_PAGE, zp_sum};
                    state <= (dec.mode == cpu_decode_pkg::M_INDX) ? S_PTR_LO : S_READ;
                end
                S_PTR_LO: begin
                    ea[7:0] <= mem_data_in;
                    ea_bus <= {cpu_decode_pkg::ZERO_PAGE, ptr + 8'h01};
                    state <= S_PTR_HI;
                end
                S_OPER2, S_PTR_HI: begin
                    ea <= {mem_data_in, idx_sum[7:0]};
                    ea_bus <= {mem_data_in, idx_sum[7:0]};
                    state <= idx_sum[8] ? S_FIXHI : S_READ;
                end
                S_FIXHI: begin
                    ea_bus <= {ea[15:8] + 8'h01, ea[7:0]};
                    state <= S_READ;
                end
                S_READ: begin
                    ea_bus <= pc;
                    state <= S_FETCH;
                end
                S_BR_TAKE: begin
                    // Second dummy cycle only when the high byte must be fixed
                    if (br_fix) begin
                        br_fix <= 1'b0;
                        ea_bus <= pc;
                        state <= S_FETCH;
                    end else if (br_cross) begin
                        br_fix <= 1'b1;
                        ea_bus <= {pc[15:8], br_target[7:0]};
                    end else begin
                        ea_bus <= br_target;
                        state <= S_FETCH;
                    end
                end
                default: begin
                    state <= S_FETCH;
                end
            endcase
        end
    end

    // Program counter
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pc <= cpu_decode_pkg::PC_RESET;
        end else if (sw_wr && reg_addr_in == cpu_decode_pkg::REG_PCL) begin
            pc[7:0] <= reg_wdata_in;
        end else if (sw_wr && reg_addr_in == cpu_decode_pkg::REG_PCH) begin
            pc[15:8] <= reg_wdata_in;
        end else if (state == S_BR_TAKE && !br_fix) begin
            pc <= br_target;
        end else if ((state == S_FETCH && run && dec.kind != cpu_decode_pkg::K_BAD)
                || state == S_OPER1 || state == S_OPER2) begin
            pc <= pc + 16'h0001;
        end
    end

    // Status flags
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stat <= cpu_decode_pkg::STAT_RESET;
        end else if (sw_wr && reg_addr_in == cpu_decode_pkg::REG_STAT) begin
            stat <= reg_wdata_in;
        end else if (acmp_exec) begin
            stat[cpu_decode_pkg::FLAG_C] <= acc >= mem_data_in;
            stat[cpu_decode_pkg::FLAG_Z] <= acc == mem_data_in;
            stat[cpu_decode_pkg::FLAG_N] <= acmp_diff[7];
        end else if (state == S_IMPL) begin
            case (dec.kind)
                cpu_decode_pkg::K_CLRD: stat[cpu_decode_pkg::FLAG_D] <= 1'b0;
                cpu_decode_pkg::K_CLRI: stat[cpu_decode_pkg::FLAG_I] <= 1'b0;
                cpu_decode_pkg::K_CLRV: stat[cpu_decode_pkg::FLAG_V] <= 1'b0;
                default: stat <= stat;
            endcase
        end
    end

    // Result is only looked at for its sign; the accumulator is never written
    assign acmp_diff = acc - mem_data_in;

    // Software-owned data registers
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc <= cpu_decode_pkg::ZERO_PAGE;
            xidx <= cpu_decode_pkg::ZERO_PAGE;
            yidx <= cpu_decode_pkg::ZERO_PAGE;
        end else if (sw_wr) begin
            if (reg_addr_in == cpu_decode_pkg::REG_ACC) begin
                acc <= reg_wdata_in;
            end else if (reg_addr_in == cpu_decode_pkg::REG_XIDX) begin
                xidx <= reg_wdata_in;
            end else if (reg_addr_in == cpu_decode_pkg::REG_YIDX) begin
                yidx <= reg_wdata_in;
            end
        end
    end

    // Run control; an unknown opcode stops the core and is latched
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run <= 1'b0;
            bad_op <= 1'b0;
        end else begin
            if (state == S_FETCH && run && dec.kind == cpu_decode_pkg::K_BAD) begin
                run <= 1'b0;
                bad_op <= 1'b1;
            end else begin
                if (reg_wr_in && reg_addr_in == cpu_decode_pkg::REG_CTRL) begin
                    run <= reg_wdata_in[cpu_decode_pkg::CTRL_RUN];
                end
                if (reg_wr_in && reg_addr_in == cpu_decode_pkg::REG_INFO
                        && reg_wdata_in[cpu_decode_pkg::INFO_BAD]) begin
                    bad_op <= 1'b0;
                end
            end
        end
    end

    // Stopping mid-instruction still needs valid operand reads to finish it
    assign mem_rd_out = run || (state != S_FETCH);

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= cpu_decode_pkg::ZERO_PAGE;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= cpu_decode_pkg::ZERO_PAGE;
        end else if (reg_addr_in == cpu_decode_pkg::REG_CTRL) begin
            reg_rdata_out <= {7'h00, run};
        end else if (reg_addr_in == cpu_decode_pkg::REG_STAT) begin
            reg_rdata_out <= stat;
        end else if (reg_addr_in == cpu_decode_pkg::REG_ACC) begin
            reg_rdata_out <= acc;
        end else if (reg_addr_in == cpu_decode_pkg::REG_XIDX) begin
            reg_rdata_out <= xidx;
        end else if (reg_addr_in == cpu_decode_pkg::REG_YIDX) begin
            reg_rdata_out <= yidx;
        end else if (reg_addr_in == cpu_decode_pkg::REG_PCL) begin
            reg_rdata_out <= pc[7:0];
        end else if (reg_addr_in == cpu_decode_pkg::REG_PCH) begin
            reg_rdata_out <= pc[15:8];
        end else if (reg_addr_in == cpu_decode_pkg::REG_INFO) begin
            reg_rdata_out <= {6'h00, bad_op, idle};
        end else begin
            reg_rdata_out <= cpu_decode_pkg::ZERO_PAGE;
        end
    end

    // Cycles since the last opcode fetch, checked below
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cyc_cnt <= 3'h0;
        end else if (state == S_FETCH && run && dec.kind != cpu_decode_pkg::K_BAD) begin
            // A halting fetch keeps the count of the instruction before it
            cyc_cnt <= 3'h1;
        end else if (state != S_FETCH) begin
            cyc_cnt <= cyc_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    set_take_a: assert property (
        state == S_OPER1 && dec.kind == cpu_decode_pkg::K_BR_SET
        && stat[cpu_decode_pkg::FLAG_V] |=> state == S_BR_TAKE)
        else $error("set-overflow branch not taken");
    set_fall_a: assert property (
        state == S_OPER1 && dec.kind == cpu_decode_pkg::K_BR_SET
        && !stat[cpu_decode_pkg::FLAG_V] |=> state == S_FETCH && pc == $past(pc) + 16'h0001)
        else $error("set-overflow branch did not fall through");
    clr_take_a: assert property (
        state == S_OPER1 && dec.kind == cpu_decode_pkg::K_BR_CLR
        && !stat[cpu_decode_pkg::FLAG_V] |=> state == S_BR_TAKE)
        else $error("clear-overflow branch not taken");
    clr_fall_a: assert property (
        state == S_OPER1 && dec.kind == cpu_decode_pkg::K_BR_CLR
        && stat[cpu_decode_pkg::FLAG_V] |=> state == S_FETCH)
        else $error("clear-overflow branch did not fall through");
    same_page_a: assert property (
        state == S_BR_TAKE && !br_fix && !br_cross |=> state == S_FETCH && pc == ea_bus)
        else $error("same-page branch took wrong time");
    cross_page_a: assert property (
        state == S_BR_TAKE && !br_fix && br_cross |=> state == S_BR_TAKE ##1 state == S_FETCH)
        else $error("page-crossing branch took wrong time");
    clear_dec_a: assert property (
        state == S_IMPL && dec.kind == cpu_decode_pkg::K_CLRD |=> !stat[cpu_decode_pkg::FLAG_D]
        && (stat | cpu_decode_pkg::MASK_D) == ($past(stat) | cpu_decode_pkg::MASK_D))
        else $error("decimal clear wrong");
    clear_irq_a: assert property (
        state == S_IMPL && dec.kind == cpu_decode_pkg::K_CLRI |=> !stat[cpu_decode_pkg::FLAG_I]
        && (stat | cpu_decode_pkg::MASK_I) == ($past(stat) | cpu_decode_pkg::MASK_I))
        else $error("interrupt-disable clear wrong");
    clear_ovf_a: assert property (
        state == S_IMPL && dec.kind == cpu_decode_pkg::K_CLRV |=> !stat[cpu_decode_pkg::FLAG_V]
        && (stat | cpu_decode_pkg::MASK_V) == ($past(stat) | cpu_decode_pkg::MASK_V))
        else $error("overflow clear wrong");
    acmp_flags_a: assert property (
        acmp_exec |=> stat[cpu_decode_pkg::FLAG_C] == ($past(acc) >= $past(mem_data_in))
        && stat[cpu_decode_pkg::FLAG_Z] == ($past(acc) == $past(mem_data_in))
        && (stat & ~cpu_decode_pkg::MASK_NZC) == ($past(stat) & ~cpu_decode_pkg::MASK_NZC)
        && acc == $past(acc))
        else $error("compare flags wrong");
    acmp_len_a: assert property (
        state == S_FETCH && cyc_cnt != 3'h0 |->
        (opcode != cpu_decode_pkg::OP_ACMP_IMM || cyc_cnt == cpu_decode_pkg::LEN_ACMP_IMM)
        && (opcode != cpu_decode_pkg::OP_ACMP_ZP || cyc_cnt == cpu_decode_pkg::LEN_ACMP_ZP)
        && (opcode != cpu_decode_pkg::OP_ACMP_INDX || cyc_cnt == cpu_decode_pkg::LEN_ACMP_INDX))
        else $error("compare cycle count wrong");
endmodule

/* File: cpu_branch_flag_compare_decode_test.sv */
// Purpose: Self-checking bench for branch, flag clear and compare execution
// Assumes: Opcode 00 is undecoded and halts the core, so each program ends there
// Notes: Cycle count is mem_rd_out high time, one more than the instruction
`timescale 1ns/1ps
module cpu_branch_flag_compare_decode_test;
    logic clock_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_seen = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, mem_data_in, a, m, s, d;
    logic [15:0] mem_addr_out;
    logic mem_rd_out;
    logic [7:0] exp_q[$];
    int err_total = 0, n_compared = 0, seed = 32'h960c, cnt;
    logic [7:0] ops[8] = '{8'hC9, 8'hC5, 8'hD5, 8'hCD, 8'hDD, 8'hD9, 8'hC1, 8'hD1};
    logic [7:0] b1s[8] = '{8'h00, 8'h40, 8'hFE, 8'h00, 8'hFE, 8'h00, 8'h60, 8'h70};
    logic [7:0] b2s[8] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h30, 8'h31, 8'h00, 8'h00};
    logic [15:0] effs[8] = '{16'h0201, 16'h0040, 16'h0003, 16'h3000, 16'h3103, 16'h31F0,
        16'h3400, 16'h3510};
    int cycs[8] = '{3, 4, 5, 5, 6, 5, 7, 7};
    cpu_branch_flag_compare_decode i_cpu_branch_flag_compare_decode (.clock_in(clock_in),
        .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out), .mem_data_in(mem_data_in));
    prog_mem i_prog_mem (.clock_in(clock_in), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
        .data_out(mem_data_in));
    initial begin
        forever #2 clock_in = ~clock_in;
    end
    task end_sim;
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge clock_in) begin
        if (rd_seen) check("read data", {8'h00, reg_rdata_out}, {8'h00, exp_q.pop_front()});
        rd_seen <= reg_rd_in;
    end
    task wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clock_in);
        reg_addr_in <= ad;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [3:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clock_in);
        reg_addr_in <= ad;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
    endtask
    // Loads state, runs until the halt, then reads back flags, PC, ACC and INFO
    task go(input logic [15:0] pc, input logic [7:0] st, input logic [15:0] epc,
        input logic [7:0] est, input int ecyc);
        int n;
        wr(cpu_decode_pkg::REG_PCL, pc[7:0]);
        wr(cpu_decode_pkg::REG_PCH, pc[15:8]);
        wr(cpu_decode_pkg::REG_STAT, st);
        wr(cpu_decode_pkg::REG_ACC, a);
        wr(cpu_decode_pkg::REG_XIDX, 8'h05);
        wr(cpu_decode_pkg::REG_YIDX, 8'hF0);
        wr(cpu_decode_pkg::REG_INFO, 8'h02);
        wr(cpu_decode_pkg::REG_CTRL, 8'h01);
        cnt = 0;
        n = 0;
        #1;
        while (n < 60 && !(cnt > 0 && mem_rd_out !== 1'b1)) begin
            if (mem_rd_out === 1'b1) cnt++;
            @(posedge clock_in);
            #1;
            n++;
        end
        check("cycles", cnt[15:0], ecyc[15:0]);
        rd(cpu_decode_pkg::REG_STAT, est);
        rd(cpu_decode_pkg::REG_PCL, epc[7:0]);
        rd(cpu_decode_pkg::REG_PCH, epc[15:8]);
        rd(cpu_decode_pkg::REG_ACC, a);
        rd(cpu_decode_pkg::REG_INFO, 8'h03);
    endtask
    initial begin
        #20000;
        err_total++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clock_in);
        nrst_in <= 1'b1;
        {i_prog_mem.mem[16'h0A10], i_prog_mem.mem[16'h0A20], i_prog_mem.mem[16'h0A30]} =
            {cpu_decode_pkg::OP_CLRD, cpu_decode_pkg::OP_CLRI, cpu_decode_pkg::OP_CLRV};
        {i_prog_mem.mem[16'h0A40], i_prog_mem.mem[16'h0A41]} = {cpu_decode_pkg::OP_BRVS, 8'h05};
        {i_prog_mem.mem[16'h0AF0], i_prog_mem.mem[16'h0AF1]} = {cpu_decode_pkg::OP_BRVC, 8'h20};
        {i_prog_mem.mem[16'h0A50], i_prog_mem.mem[16'h0A51]} = {cpu_decode_pkg::OP_BRVC, 8'hF0};
        {i_prog_mem.mem[16'h0065], i_prog_mem.mem[16'h0066]} = 16'h0034;
        {i_prog_mem.mem[16'h0070], i_prog_mem.mem[16'h0071]} = 16'h2034;
        a = 8'($random(seed));
        go(16'h0A10, 8'hFF, 16'h0A11, 8'hF7, 3);
        go(16'h0A20, 8'hFF, 16'h0A21, 8'hFB, 3);
        go(16'h0A30, 8'hFF, 16'h0A31, 8'hBF, 3);
        go(16'h0A40, 8'h40, 16'h0A47, 8'h40, 4);
        go(16'h0A40, 8'hBF, 16'h0A42, 8'hBF, 3);
        go(16'h0AF0, 8'h00, 16'h0B12, 8'h00, 5);
        go(16'h0AF0, 8'hC3, 16'h0AF2, 8'hC3, 3);
        go(16'h0A50, 8'hBF, 16'h0A42, 8'hBF, 4);
        for (int i = 0; i < 8; i++) begin
            a = 8'($random(seed));
            m = (i % 3 == 0) ? a : 8'($random(seed));
            s = 8'($random(seed));
            d = a - m;
            i_prog_mem.mem[16'h0200] = ops[i];
            i_prog_mem.mem[16'h0201] = b1s[i];
            i_prog_mem.mem[16'h0202] = (i inside {3, 4, 5}) ? b2s[i] : 8'h00;
            i_prog_mem.mem[16'h0203] = 8'h00;
            i_prog_mem.mem[effs[i]] = m;
            go(16'h0200, s, (i inside {3, 4, 5}) ? 16'h0203 : 16'h0202,
                (s & 8'h7C) | {d[7], 5'h00, d == 8'h00, a >= m}, cycs[i]);
        end
        repeat (3) @(posedge clock_in);
        end_sim;
    end
endmodule

/* File: cpu_decode_pkg.sv */
// Purpose: Shared constants and types for the overflow branch, flag clear and compare core
// Assumes: 8-bit data, 16-bit addresses, status byte laid out N V - - D I Z C
// Notes: Register port offsets are word indices on a small 4-bit address
package cpu_decode_pkg;
    localparam logic [7:0] OP_BRVS = 8'h70;
    localparam logic [7:0] OP_BRVC = 8'h50;
    localparam logic [7:0] OP_CLRD = 8'hD8;
    localparam logic [7:0] OP_CLRI = 8'h58;
    localparam logic [7:0] OP_CLRV = 8'hB8;
    localparam logic [7:0] OP_ACMP_IMM = 8'hC9;
    localparam logic [7:0] OP_ACMP_ZP = 8'hC5;
    localparam logic [7:0] OP_ACMP_ZPX = 8'hD5;
    localparam logic [7:0] OP_ACMP_ABS = 8'hCD;
    localparam logic [7:0] OP_ACMP_ABSX = 8'hDD;
    localparam logic [7:0] OP_ACMP_ABSY = 8'hD9;
    localparam logic [7:0] OP_ACMP_INDX = 8'hC1;
    localparam logic [7:0] OP_ACMP_INDY = 8'hD1;

    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_I = 2;
    localparam int FLAG_D = 3;
    localparam int FLAG_V = 6;
    localparam int FLAG_N = 7;
    localparam logic [7:0] MASK_D = 8'h08;
    localparam logic [7:0] MASK_I = 8'h04;
    localparam logic [7:0] MASK_V = 8'h40;
    localparam logic [7:0] MASK_NZC = 8'h83;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_ACC = 4'h2;
    localparam logic [3:0] REG_XIDX = 4'h3;
    localparam logic [3:0] REG_YIDX = 4'h4;
    localparam logic [3:0] REG_PCL = 4'h5;
    localparam logic [3:0] REG_PCH = 4'h6;
    localparam logic [3:0] REG_INFO = 4'h7;
    localparam int CTRL_RUN = 0;
    localparam int INFO_IDLE = 0;
    localparam int INFO_BAD = 1;

    localparam logic [7:0] STAT_RESET = 8'h04;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] ZERO_PAGE = 8'h00;

    localparam logic [2:0] LEN_ACMP_IMM = 3'h2;
    localparam logic [2:0] LEN_ACMP_ZP = 3'h3;
    localparam logic [2:0] LEN_ACMP_INDX = 3'h6;

    typedef enum logic [2:0] {
        K_BAD, K_BR_SET, K_BR_CLR, K_CLRD, K_CLRI, K_CLRV, K_ACMP
    } kind_e;

    typedef enum logic [3:0] {
        M_NONE, M_REL, M_IMM, M_ZP, M_ZPX, M_ABS, M_ABSX, M_ABSY, M_INDX, M_INDY
    } mode_e;
endpackage

/* File: cpu_op_decode.sv */
// Purpose: Maps an opcode onto instruction class and addressing mode
// Assumes: Only the overflow branches, three flag clears and compare are legal
// Notes: Every other opcode decodes as K_BAD
`timescale 1ns/1ps
module cpu_op_decode (
    decode_if.decoder dec // Opcode in, class and mode out
);
    always_comb begin
        dec.kind = cpu_decode_pkg::K_ACMP;
        dec.mode = cpu_decode_pkg::M_NONE;
        case (dec.opcode)
            cpu_decode_pkg::OP_BRVS: begin
                dec.kind = cpu_decode_pkg::K_BR_SET;
                dec.mode = cpu_decode_pkg::M_REL;
            end
            cpu_decode_pkg::OP_BRVC: begin
                dec.kind = cpu_decode_pkg::K_BR_CLR;
                dec.mode = cpu_decode_pkg::M_REL;
            end
            cpu_decode_pkg::OP_CLRD: dec.kind = cpu_decode_pkg::K_CLRD;
            cpu_decode_pkg::OP_CLRI: dec.kind = cpu_decode_pkg::K_CLRI;
            cpu_decode_pkg::OP_CLRV: dec.kind = cpu_decode_pkg::K_CLRV;
            cpu_decode_pkg::OP_ACMP_IMM: dec.mode = cpu_decode_pkg::M_IMM;
            cpu_decode_pkg::OP_ACMP_ZP: dec.mode = cpu_decode_pkg::M_ZP;
            cpu_decode_pkg::OP_ACMP_ZPX: dec.mode = cpu_decode_pkg::M_ZPX;
            cpu_decode_pkg::OP_ACMP_ABS: dec.mode = cpu_decode_pkg::M_ABS;
            cpu_decode_pkg::OP_ACMP_ABSX: dec.mode = cpu_decode_pkg::M_ABSX;
            cpu_decode_pkg::OP_ACMP_ABSY: dec.mode = cpu_decode_pkg::M_ABSY;
            cpu_decode_pkg::OP_ACMP_INDX: dec.mode = cpu_decode_pkg::M_INDX;
            cpu_decode_pkg::OP_ACMP_INDY: dec.mode = cpu_decode_pkg::M_INDY;
            default: dec.kind = cpu_decode_pkg::K_BAD;
        endcase
    end
endmodule

/* File: decode_if.sv */
// Purpose: Carries an opcode to the decoder and its class and addressing mode back
// Assumes: Purely combinational path inside one clock domain
// Notes: None
`timescale 1ns/1ps
interface decode_if;
    logic [7:0] opcode;
    cpu_decode_pkg::kind_e kind;
    cpu_decode_pkg::mode_e mode;
    modport decoder (input opcode, output kind, output mode);
    modport core (output opcode, input kind, input mode);
endinterface

/* File: prog_mem.sv */
// Purpose: Zero-wait program and data memory on the far side of the core
// Assumes: Testbench preloads bytes by hierarchical write while the core is idle
// Notes: An unselected bus shows the inverse of the last byte read
`timescale 1ns/1ps
module prog_mem (
    input wire logic clock_in, // System clock
    input wire logic [15:0] addr_in, // Address from the core
    input wire logic rd_in, // Read enable
    output logic [7:0] data_out // Read data, same cycle
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    // Inverted stale byte so a read outside a strobe can never match by luck
    assign data_out = rd_in ? mem[addr_in] : ~last;
    always @(posedge clock_in) begin
        if (rd_in) begin
            last <= mem[addr_in];
        end
    end
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end
endmodule
